// [chip_select_defines.vh]
/*
 * Decoder and pin counts, register offsets, field positions and reset values for the
 * chip-select region decoder.
 * Assumes inclusion by bare name from design and verification files.
 */
`ifndef CHIP_SELECT_DEFINES_VH
`define CHIP_SELECT_DEFINES_VH

// Decoders: 0 boot, 1..5 regions, 6 boot dedicated sub-block
`define CS_NUM_DEC        7
`define CS_NUM_PINS       12
`define CS_SUB_DEC        6
// APB map: option regs at 0x00 + 4*i, origin regs at 0x40 + 4*i
`define CS_OPT_BASE       8'h00
`define CS_ORG_BASE       8'h40
`define CS_STAT_ADDR      8'h80
// Option fields, bit numbers counted from the LSB (doc bit n -> 31-n)
`define CS_SPAN_HI        31
`define CS_SPAN_LO        28
`define CS_NEST_BIT       27
`define CS_SUPV_BIT       26
`define CS_DSP_BIT        25
`define CS_WP_BIT         24
`define CS_CI_BIT         23
`define CS_AUTO_ACK_SWITCH_BIT      18
`define CS_WAIT_HI        17
`define CS_WAIT_LO        15
`define CS_PW_HI          14
`define CS_PW_LO          13
`define CS_PFN_HI         12
`define CS_PFN_LO         11
`define CS_LANE_HI        10
`define CS_LANE_LO        9
`define CS_REG_HI         8
`define CS_REG_LO         6
`define CS_KIND_HI        3
`define CS_KIND_LO        0
// Origin field: upper 20 bits of the address
`define CS_ORG_HI         31
`define CS_ORG_LO         12
// Pin function codes
`define CS_PFN_CE         2'h0
`define CS_PFN_WE         2'h1
`define CS_PFN_OE         2'h2
`define CS_PFN_ALT        2'h3
// Port width codes
`define CS_PW_16          2'h1
`define CS_PW_32          2'h2
// Reset values: boot region on, 64M, auto ack, 1 wait, port width code 3, output enable
`define CS_BOOT_OPT_RST   32'hF004F400
`define CS_OPT_RST        32'h00000000
`define CS_NONBOOT_PFN    32'h00001800
`define CS_BOOT_ORG_LOW   20'h00000
`define CS_BOOT_ORG_HIGH  20'hFFF00

`endif

// [chip_select_region_decoder.v]
/*
 * Chip-select region decoder: APB register file, address decode of six
 * regions plus a boot sub-block, protection, wait-state acknowledge and
 * strobe pins.
 * Assumes a processor bus synchronous to sys_clk_i with a one-cycle
 * cycle_begin pulse and address held until the cycle ends.
 */
`timescale 1ns/1ps
`default_nettype none
`include "chip_select_defines.vh"

module chip_select_region_decoder (
    input  wire        sys_clk_i,
    input  wire        reset_i,
    input  wire [7:0]  paddr_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        exception_prefix_bit_i,
    input  wire        cycle_begin_i,
    input  wire [31:0] bus_addr_i,
    input  wire        bus_write_i,
    input  wire [3:0]  byte_en_i,
    input  wire        supervisor_i,
    input  wire        instr_fetch_i,
    input  wire        internal_hit_i,
    input  wire        ext_transfer_ack_i,
    output reg  [11:0] select_n_o,
    output reg         transfer_ack_o,
    output reg         addr_phase_ack_o,
    output reg         bus_fault_ack_o,
    output reg  [1:0]  port_width_o,
    output reg         cache_inhibit_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [31:0] opt_q [0:`CS_NUM_PINS-1];
    reg  [19:0] org_q [0:`CS_NUM_DEC-1];
    reg  [2:0]  state_q;
    reg  [2:0]  wait_q;
    reg         auto_q;
    reg  [11:0] pins_q;
    reg         fault_seen_q;
    reg         strap_done_q;
    reg  [6:0]  hit;
    reg  [19:0] mask;
    reg  [3:0]  span;
    reg  [5:0]  region_hit;
    reg  [31:0] prot;
    reg  [31:0] handshake;
    reg         violate;
    reg  [2:0]  main_idx;
    reg  [2:0]  rsel;
    reg         any_hit;
    reg  [11:0] pins_d;
    reg  [31:0] rd_d;
    reg         err_d;
    integer     i;

    wire        apb_acc = psel_i & penable_i;
    wire [3:0]  widx    = paddr_i[5:2];
    // Status: sticky fault flag, latched pins, busy
    wire [31:0] status_w = {18'h00000, fault_seen_q, pins_q, state_q != ST_IDLE};

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            strap_done_q <= 1'b0;
            for (i = 0; i < `CS_NUM_DEC; i = i + 1) begin
                org_q[i] <= 20'h00000;
            end
            // Strobe-only pins come up as alternate function
            for (i = 0; i < `CS_NUM_PINS; i = i + 1) begin
                opt_q[i] <= (i == 0) ? `CS_BOOT_OPT_RST :
                            (i > 5 && i < `CS_NUM_PINS) ? `CS_NONBOOT_PFN : `CS_OPT_RST;
            end
        end else begin
            // Prefix bit is settled by the first clock after reset
            // Boot origin strapped once after release
            if (!strap_done_q) begin
                strap_done_q <= 1'b1;
                org_q[0] <= exception_prefix_bit_i ? `CS_BOOT_ORG_HIGH : `CS_BOOT_ORG_LOW;
            end
            // Refused writes leave every register untouched
            if (apb_acc && pwrite_i && !err_d) begin
                if (paddr_i[7:6] == 2'b00)
                    opt_q[widx] <= pwdata_i;
                else if (paddr_i[7:6] == 2'b01)
                    org_q[widx[2:0]] <= pwdata_i[`CS_ORG_HI:`CS_ORG_LO];
            end
        end
    end

    // APB decode and read mux
    always @* begin
        rd_d  = 32'h00000000;
        err_d = 1'b0;
        if (paddr_i[1:0] != 2'b00)
            err_d = 1'b1;
        else if (paddr_i[7:6] == 2'b00 && widx < `CS_NUM_PINS)
            rd_d = opt_q[widx];
        else if (paddr_i[7:6] == 2'b01 && widx < `CS_NUM_DEC)
            rd_d = {org_q[widx[2:0]], 12'h000};
        else if (paddr_i == `CS_STAT_ADDR)
            rd_d = status_w;
        else
            err_d = 1'b1;
    end

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            // Answer in the access phase, one clock after setup
            pready_o  <= psel_i & ~penable_i;
            prdata_o  <= rd_d;
            pslverr_o <= psel_i & ~penable_i & err_d;
        end
    end

    // Decode and protection
    always @* begin
        hit        = 7'h00;
        region_hit = 6'h00;
        mask       = 20'h00000;
        span       = 4'h0;
        prot       = 32'h00000000;
        handshake  = 32'h00000000;
        violate    = 1'b0;
        main_idx   = 3'd0;
        any_hit    = 1'b0;
        rsel       = 3'd0;
        pins_d     = 12'hFFF;
        for (i = 0; i < `CS_NUM_DEC; i = i + 1) begin
            // Boot dedicated sub-block reads the last option register
            span = (i == `CS_SUB_DEC) ? opt_q[`CS_NUM_PINS-1][`CS_SPAN_HI:`CS_SPAN_LO]
                                      : opt_q[i][`CS_SPAN_HI:`CS_SPAN_LO];
            // Code 1 shifts by zero and compares all twenty bits
            // One low bit dropped per doubling
            mask = 20'hFFFFF << (span - 4'h1);
            hit[i] = (span != 4'h0) &&
                     (((bus_addr_i[`CS_ORG_HI:`CS_ORG_LO] ^ org_q[i]) & mask) == 20'h00000);
        end
        for (i = 0; i < 6; i = i + 1) begin
            // Lowest matching main block wins; sub-blocks never do
            if (hit[i] && !(i[0] && opt_q[i][`CS_NEST_BIT]) && !any_hit) begin
                any_hit  = 1'b1;
                main_idx = i[2:0];
            end
        end
        prot      = opt_q[main_idx];
        handshake = opt_q[main_idx];
        // Pair member overrides; boot dedicated lower priority
        if (any_hit) begin
            if (main_idx == 3'd0 && hit[`CS_SUB_DEC] && opt_q[`CS_NUM_PINS-1][`CS_NEST_BIT])
                prot = opt_q[`CS_NUM_PINS-1];
            if (!main_idx[0] && hit[main_idx+3'd1] && opt_q[main_idx+3'd1][`CS_NEST_BIT]) begin
                prot      = opt_q[main_idx+3'd1];
                // Mismatched handshake fields are merged bit by bit
                handshake = opt_q[main_idx] | opt_q[main_idx+3'd1];
            end
            // Supervisor check applies to data accesses only
            violate = (prot[`CS_SUPV_BIT] & ~supervisor_i & ~instr_fetch_i) |
                      (prot[`CS_DSP_BIT] & instr_fetch_i) |
                      (prot[`CS_WP_BIT] & bus_write_i);
            // Main block's region is the one reported
            region_hit[main_idx] = 1'b1;
        end
        // Internal hit wins: no external cycle
        if (internal_hit_i) begin
            region_hit = 6'h00;
            violate    = 1'b0;
        end
        // No chip enable on a violation
        if (violate)
            region_hit = 6'h00;
        for (i = 0; i < `CS_NUM_PINS; i = i + 1) begin
            rsel = opt_q[i][`CS_REG_HI:`CS_REG_LO];
            // Pin function; chip enable only on pins 0 to 5
            case (opt_q[i][`CS_PFN_HI:`CS_PFN_LO])
                `CS_PFN_CE:
                    // A sub-block pin cannot drive a chip enable
                    if (i < 6 && !(i[0] && opt_q[i][`CS_NEST_BIT]))
                        pins_d[i] = ~region_hit[i];
                `CS_PFN_WE:
                    if (rsel < 3'd6)
                        pins_d[i] = ~(region_hit[rsel] & bus_write_i &
                                      byte_en_i[opt_q[i][`CS_LANE_HI:`CS_LANE_LO]]);
                `CS_PFN_OE:
                    if (rsel < 3'd6)
                        pins_d[i] = ~(region_hit[rsel] & ~bus_write_i);
                default:
                    pins_d[i] = 1'b1;
            endcase
        end
    end

    // Cycle sequencer
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q          <= ST_IDLE;
            wait_q           <= 3'd0;
            auto_q           <= 1'b0;
            pins_q           <= 12'hFFF;
            fault_seen_q     <= 1'b0;
            select_n_o       <= 12'hFFF;
            transfer_ack_o   <= 1'b0;
            addr_phase_ack_o <= 1'b0;
            bus_fault_ack_o  <= 1'b0;
            port_width_o     <= `CS_PW_32;
            cache_inhibit_o  <= 1'b0;
        end else begin
            transfer_ack_o   <= 1'b0;
            addr_phase_ack_o <= 1'b0;
            bus_fault_ack_o  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cycle_begin_i && any_hit && !internal_hit_i) begin
                        pins_q          <= pins_d;
                        select_n_o      <= pins_d;
                        port_width_o    <= handshake[`CS_PW_HI:`CS_PW_LO];
                        cache_inhibit_o <= prot[`CS_CI_BIT];
                        if (violate) begin
                            bus_fault_ack_o <= 1'b1;
                            fault_seen_q    <= 1'b1;
                            state_q         <= ST_DONE;
                        end else begin
                            auto_q  <= handshake[`CS_AUTO_ACK_SWITCH_BIT];
                            addr_phase_ack_o <= handshake[`CS_AUTO_ACK_SWITCH_BIT];
                            wait_q  <= handshake[`CS_WAIT_HI:`CS_WAIT_LO];
                            if (handshake[`CS_WAIT_HI:`CS_WAIT_LO] == 3'd0 ||
                                ext_transfer_ack_i) begin
                                transfer_ack_o <= handshake[`CS_AUTO_ACK_SWITCH_BIT] & ~ext_transfer_ack_i;
                                state_q <= handshake[`CS_AUTO_ACK_SWITCH_BIT] | ext_transfer_ack_i
                                           ? ST_DONE : ST_WAIT;
                            end else
                                state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (wait_q > 3'd1)
                        wait_q <= wait_q - 3'd1;
                    // An external acknowledge ends the cycle at once
                    if (ext_transfer_ack_i)
                        state_q <= ST_DONE;
                    else if (auto_q && wait_q <= 3'd1) begin
                        transfer_ack_o <= 1'b1;
                        state_q        <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Selects drop one clock after the acknowledge
                    pins_q     <= 12'hFFF;
                    select_n_o <= 12'hFFF;
                    state_q    <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // chip_select_region_decoder
`default_nettype wire

// [cs_decoder_checker_assertions.sv]
/* Checker for the chip-select region decoder, bound to its ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cs_decoder_checker (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        cycle_begin_i,
    input wire logic        internal_hit_i,
    input wire logic [11:0] select_n_o,
    input wire logic        transfer_ack_o,
    input wire logic        addr_phase_ack_o,
    input wire logic        bus_fault_ack_o
);
    logic [3:0] since_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // Clocks since the last cycle start, saturating
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) since_q <= 4'hF;
        else if (cycle_begin_i) since_q <= 4'h1;
        else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
    sequence s_sel_fall;
        $fell(&select_n_o);
    endsequence
    sequence s_all_idle;
        (&select_n_o) && !transfer_ack_o;
    endsequence
    a_ack_wait_bound: assert property (
        transfer_ack_o |-> since_q inside {[4'h1:4'h8]}) else $error("ack outside wait window");
    a_ack_pulse: assert property (
        transfer_ack_o |=> !transfer_ack_o) else $error("transfer ack longer than one clock");
    a_ack_release: assert property (
        transfer_ack_o |=> s_all_idle) else $error("selects held after ack");
    a_fault_no_ce: assert property (
        bus_fault_ack_o |-> (&select_n_o[5:0])) else $error("chip enable during fault");
    a_fault_timing: assert property (
        bus_fault_ack_o |-> since_q == 4'h1) else $error("fault not one clock after start");
    a_addr_phase_ack_with_sel: assert property (
        addr_phase_ack_o |-> since_q == 4'h1 && !(&select_n_o[5:0]))
        else $error("address ack without chip enable");
    a_ack_exclusive: assert property (
        !(transfer_ack_o && bus_fault_ack_o)) else $error("ack and fault together");
    a_one_ce_pin: assert property (
        $countones(~select_n_o[5:0]) <= 1) else $error("two chip enables at once");
    a_sel_cause: assert property (
        s_sel_fall |-> $past(cycle_begin_i)) else $error("select without cycle start");
    a_internal_wins: assert property (
        cycle_begin_i && internal_hit_i && (&select_n_o) |=> s_all_idle)
        else $error("external cycle on internal hit");
endmodule // cs_decoder_checker
bind chip_select_region_decoder cs_decoder_checker u_chk (.sys_clk_i, .reset_i,
    .cycle_begin_i, .internal_hit_i, .select_n_o, .transfer_ack_o, .addr_phase_ack_o,
    .bus_fault_ack_o);
`default_nettype wire

// [ext_memory_model.sv]
/* External memory that acknowledges selected cycles after a delay.
   Assumes active-low chip enables from the decoder. */
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model #(
    parameter int DELAY = 3
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       ack_en_i,
    input  wire logic [5:0] ce_n_i,
    output var  logic       ext_ack_o
);
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || (&ce_n_i)) begin
            cnt_q <= 4'h0;
            ext_ack_o <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
            ext_ack_o <= ack_en_i && (cnt_q == DELAY[3:0]);
        end
    end
endmodule // ext_memory_model
`default_nettype wire

// [tb.sv]
/* Self-checking bench for the chip-select region decoder.
   Assumes the defines header, checker and memory model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "chip_select_defines.vh"
module tb;
    logic        sys_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, cycle_begin_i = 1'b0, bus_write_i = 1'b0, ack_en = 1'b0;
    logic        supervisor_i = 1'b0, internal_hit_i = 1'b0;
    logic        exception_prefix_bit_i = 1'b1, instr_fetch_i = 1'b0;
    logic [3:0]  byte_en_i = 4'hF;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, bus_addr_i = 32'h0, prdata_o;
    logic        pready_o, pslverr_o, ext_ack, transfer_ack_o, addr_phase_ack_o;
    logic        bus_fault_ack_o, cache_inhibit_o;
    logic [11:0] select_n_o;
    logic [1:0]  port_width_o;
    logic [46:0] bus_q[$];
    logic [32:0] apb_q[$];
    int          err_count = 0, checks_done = 0, cyc = 0, addr_phase_ack_seen = 0, addr_phase_ack_exp = 0;
    chip_select_region_decoder u_dut (.sys_clk_i, .reset_i, .paddr_i, .psel_i, .penable_i,
        .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .exception_prefix_bit_i,
        .cycle_begin_i, .bus_addr_i, .bus_write_i, .byte_en_i, .supervisor_i,
        .instr_fetch_i, .internal_hit_i, .ext_transfer_ack_i(ext_ack), .select_n_o,
        .transfer_ack_o, .addr_phase_ack_o, .bus_fault_ack_o, .port_width_o, .cache_inhibit_o);
    ext_memory_model #(.DELAY(3)) u_mem (.sys_clk_i, .reset_i, .ack_en_i(ack_en),
        .ce_n_i(select_n_o[5:0]), .ext_ack_o(ext_ack));
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        apb_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [31:0] opt(input logic [3:0] sp, input logic [2:0] w,
                                        input logic [1:0] pw, input logic [3:0] prot);
        opt = 32'h0;
        opt[`CS_SPAN_HI:`CS_SPAN_LO] = sp;
        opt[`CS_NEST_BIT:`CS_WP_BIT] = prot;
        opt[`CS_AUTO_ACK_SWITCH_BIT] = 1'b1;
        opt[`CS_WAIT_HI:`CS_WAIT_LO] = w;
        opt[`CS_PW_HI:`CS_PW_LO] = pw;
    endfunction
    task automatic bus(input logic [31:0] a, input logic wr, ih, sup, input logic [1:0] kind,
                       input logic [11:0] sel, input logic [1:0] pw, input int w);
        @(posedge sys_clk_i);
        if (kind != 2'h0) bus_q.push_back({kind[1], sel, pw, cyc + 2 + w});
        if (kind == 2'h1) addr_phase_ack_exp++;
        cycle_begin_i <= 1'b1;
        bus_addr_i <= a | ($urandom & 32'h00000FFC);
        bus_write_i <= wr;
        internal_hit_i <= ih;
        supervisor_i <= sup;
        @(posedge sys_clk_i);
        cycle_begin_i <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
    endtask
    always @(posedge sys_clk_i) begin
        if (addr_phase_ack_o) begin
            addr_phase_ack_seen++;
            check("select with addr ack", &select_n_o[5:0], 1'b0);
        end
        if (psel_i && penable_i && pready_o && !pwrite_i)
            check("apb read", {pslverr_o, prdata_o}, apb_q.pop_front());
        if (transfer_ack_o || bus_fault_ack_o) begin
            if (bus_q.size() == 0) check("unexpected bus result", 1, 0);
            else check("bus result", {bus_fault_ack_o, select_n_o,
                bus_fault_ack_o ? 2'h0 : port_width_o, cyc}, bus_q.pop_front());
        end
    end
    initial begin
        #100000;
        err_count++;
        conclude();
    end
    initial begin
        logic [31:0] o;
        void'($urandom(32'h9736951C));
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rd(8'h40, {1'b0, `CS_BOOT_ORG_HIGH, 12'h000});
        rd(8'h00, {1'b0, `CS_BOOT_OPT_RST});
        rd(8'h18, {1'b0, `CS_NONBOOT_PFN});
        rd(8'h04, {1'b0, `CS_OPT_RST});
        rd(8'h84, 33'h100000000);
        rd(8'h02, 33'h100000000);
        apb(1'b1, 8'h48, 32'h10000000);
        apb(1'b1, 8'h50, 32'h20000000);
        apb(1'b1, 8'h4C, 32'h10001000);
        // every wait count, both port widths
        for (int w = 0; w < 8; w++) begin
            o = opt(4'h1, w[2:0], w[0] ? `CS_PW_16 : `CS_PW_32, 4'h0);
            apb(1'b1, 8'h08, o);
            rd(8'h08, {1'b0, o});
            bus(32'h10000000, w[0], 1'b0, 1'b0, 2'h1, 12'hFFB, w[0] ? 2'h1 : 2'h2, w);
        end
        apb(1'b1, 8'h10, opt(4'h0, 3'h0, `CS_PW_32, 4'h0));
        bus(32'h20000000, 1'b0, 1'b0, 1'b0, 2'h0, 12'hFFF, 2'h0, 0);
        bus(32'h10000000, 1'b0, 1'b1, 1'b0, 2'h0, 12'hFFF, 2'h0, 0);
        // supervisor main block, smaller write-protected sub-block
        apb(1'b1, 8'h08, opt(4'h2, 3'h0, `CS_PW_32, 4'h4));
        apb(1'b1, 8'h0C, opt(4'h1, 3'h0, `CS_PW_32, 4'h9) | (32'h00000001 << `CS_CI_BIT));
        bus(32'h10001000, 1'b1, 1'b0, 1'b1, 2'h2, 12'hFFF, 2'h0, 0);
        // user read in sub-block selects main pin
        bus(32'h10001000, 1'b0, 1'b0, 1'b0, 2'h1, 12'hFFB, 2'h2, 0);
        check("sub-block cache inhibit", cache_inhibit_o, 1'b1);
        // user access to supervisor main block
        bus(32'h10000000, 1'b1, 1'b0, 1'b0, 2'h2, 12'hFFF, 2'h0, 0);
        check("main cache inhibit", cache_inhibit_o, 1'b0);
        // instruction fetches skip the supervisor check
        instr_fetch_i <= 1'b1;
        bus(32'h10000000, 1'b0, 1'b0, 1'b0, 2'h1, 12'hFFB, 2'h2, 0);
        instr_fetch_i <= 1'b0;
        // write and output strobes bound to region two
        apb(1'b1, 8'h18, 32'h00000C80);
        apb(1'b1, 8'h1C, 32'h00001080);
        bus(32'h10000000, 1'b1, 1'b0, 1'b1, 2'h1, 12'hFBB, 2'h2, 0);
        bus(32'h10000000, 1'b0, 1'b0, 1'b1, 2'h1, 12'hF7B, 2'h2, 0);
        // write strobe stays off without its byte lane
        byte_en_i <= 4'hB;
        bus(32'h10000000, 1'b1, 1'b0, 1'b1, 2'h1, 12'hFFB, 2'h2, 0);
        apb(1'b1, 8'h08, opt(4'h2, 3'h0, `CS_PW_32, 4'h0) & 32'hFFFBFFFF);
        ack_en <= 1'b1;
        bus(32'h10000000, 1'b0, 1'b0, 1'b1, 2'h0, 12'hFFF, 2'h0, 0);
        check("select after external ack", select_n_o, 12'hFFF);
        // mid-run reset with the prefix bit clear
        exception_prefix_bit_i <= 1'b0;
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rd(8'h40, {1'b0, `CS_BOOT_ORG_LOW, 12'h000});
        rd(8'h08, {1'b0, `CS_OPT_RST});
        @(posedge sys_clk_i);
        check("addr ack count", addr_phase_ack_seen, addr_phase_ack_exp);
        check("notes left", bus_q.size() + apb_q.size(), 0);
        conclude();
    end
endmodule // tb
`default_nettype wire
